// [src/pmpi_regs.sv]
/*
  Process-image multiplexer and per-channel parameter register bank of
  a three-phase power meter. Holds three register sets and three
  selectors that fill the input data words.
  Assumes control bytes, output words and measured values are
  synchronous to clk; nonvolatile storage sits outside and copies a
  register whenever nv_save_req pulses.
*/
`timescale 1ns/1ns
module pmpi_regs #(
  parameter logic [15:0] TYPE_ID    = 16'h00a5, // Arbitrary value
  parameter logic [15:0] FW_REV     = 16'h0011, // Arbitrary value
  parameter logic [15:0] SPECIAL_ID = 16'h0000  // Arbitrary value
) (
  // Clock and reset
  input  wire logic                     clk,
  input  wire logic                     rst_b,

  // Output image from the controller
  input  wire pmpi_pkg::pmpi_byte_t     control_byte_one,
  input  wire pmpi_pkg::pmpi_byte_t     control_byte_two,
  input  wire pmpi_pkg::pmpi_byte_t     control_byte_three,
  input  wire pmpi_pkg::pmpi_word_t     output_word_one,
  input  wire pmpi_pkg::pmpi_word_t     output_word_two,
  input  wire pmpi_pkg::pmpi_word_t     output_word_three,

  // Measurement datapath
  input  wire logic [pmpi_pkg::NUM_CH-1:0][pmpi_pkg::NUM_QTY-1:0]
                    [pmpi_pkg::REG_W-1:0] meas_value,
  input  wire logic [pmpi_pkg::NUM_CH-1:0] energy_wrap,
  input  wire logic [pmpi_pkg::NUM_CH-1:0]
                    [pmpi_pkg::REG_W-1:0] diag_state,

  // Input image to the controller
  output pmpi_pkg::pmpi_word_t          input_word_one,
  output pmpi_pkg::pmpi_word_t          input_word_two,
  output pmpi_pkg::pmpi_word_t          input_word_three,
  output pmpi_pkg::pmpi_byte_t          status_byte_one,
  output pmpi_pkg::pmpi_byte_t          status_byte_two,
  output pmpi_pkg::pmpi_byte_t          status_byte_three,

  // Settings toward the datapath, per channel
  output logic [pmpi_pkg::NUM_CH-1:0]
               [pmpi_pkg::REG_W-1:0]    feature_cfg,
  output logic [pmpi_pkg::NUM_CH-1:0]
               [pmpi_pkg::REG_W-1:0]    energy_scale,
  output logic [pmpi_pkg::NUM_CH-1:0]
               [pmpi_pkg::REG_W-1:0]    ratio_divisor,
  output logic [pmpi_pkg::NUM_CH-1:0]
               [pmpi_pkg::REG_W-1:0]    minmax_count,
  output logic [pmpi_pkg::NUM_CH-1:0]
               [pmpi_pkg::REG_W-1:0]    cycle_time,
  output logic [pmpi_pkg::NUM_CH-1:0]
               [pmpi_pkg::REG_W-1:0]    gain_trim_volt,
  output logic [pmpi_pkg::NUM_CH-1:0]
               [pmpi_pkg::REG_W-1:0]    gain_trim_curr,

  // Nonvolatile copy request, one pulse per accepted write to a storage-backed register while the code word unlocks saving
  output logic [pmpi_pkg::NUM_CH-1:0]   nv_save_req,
  output pmpi_pkg::pmpi_addr_t          nv_save_addr
);
  import pmpi_pkg::*;

  // Per-channel views of the controller image
  pmpi_byte_t cb       [NUM_CH];
  pmpi_word_t out_data [NUM_CH];

  // Write decode
  logic                 wr_req   [NUM_CH];
  logic                 wr_new   [NUM_CH];
  logic [NUM_REG-1:0]   wr_dec   [NUM_CH];
  pmpi_addr_t           acc_addr [NUM_CH];
  pmpi_byte_t           last_cb_reg   [NUM_CH];
  pmpi_word_t           last_data_reg [NUM_CH];

  // Register sets, one copy per channel
  pmpi_word_t ovf_reg     [NUM_CH];
  pmpi_word_t align_reg   [NUM_CH];
  pmpi_word_t hw_rev_reg  [NUM_CH];
  pmpi_word_t vgain_reg   [NUM_CH];
  pmpi_word_t igain_reg   [NUM_CH];
  pmpi_word_t code_reg    [NUM_CH];
  pmpi_word_t feat_reg    [NUM_CH];
  pmpi_word_t scale_reg   [NUM_CH];
  pmpi_word_t uv_reg      [NUM_CH];
  pmpi_word_t ratio_reg   [NUM_CH];
  pmpi_word_t minmax_reg  [NUM_CH];
  pmpi_word_t cycle_reg   [NUM_CH];
  pmpi_word_t rdata       [NUM_CH];
  logic [NUM_CH-1:0] nv_req_reg;
  pmpi_addr_t        nv_addr_reg;

  pmpi_sel_if sel_if [NUM_CH] ();

  // Route the three control bytes and output words
  assign cb[0]       = control_byte_one;
  assign cb[1]       = control_byte_two;
  assign cb[2]       = control_byte_three;
  assign out_data[0] = output_word_one;
  assign out_data[1] = output_word_two;
  assign out_data[2] = output_word_three;

  genvar g;
  generate
    for (g = 0; g < NUM_CH; g++) begin : g_chan

      // Register access seen on this channel's control byte
      always_comb begin
        acc_addr[g] = cb[g][CB_ADR_HI:0];
        wr_req[g]   = cb[g][CB_REG_BIT] &
                      cb[g][CB_WR_BIT];
        // A held request writes once; the controller holds it until
        // it sees the acknowledge, so repeats must not retrigger
        wr_new[g]   = wr_req[g] && ((cb[g] != last_cb_reg[g]) ||
                                    (out_data[g] != last_data_reg[g]));
        wr_dec[g]   = wr_new[g] ? (64'h1 << acc_addr[g])
                                : '0;
      end

      // Remember the last request for one-shot writes
      always_ff @(posedge clk) begin
        if (!rst_b) begin
          last_cb_reg[g]   <= '0;
          last_data_reg[g] <= '0;
        end else begin
          last_cb_reg[g]   <= cb[g];
          last_data_reg[g] <= out_data[g];
        end
      end

      // Energy overflow count; a write beats a wrap in the same cycle
      always_ff @(posedge clk) begin
        if (!rst_b) begin
          ovf_reg[g] <= RST_OVERFLOW;
        end else if (wr_dec[g][OFS_OVERFLOW]) begin
          ovf_reg[g] <= out_data[g];
        end else if (energy_wrap[g]) begin
          // Wraps at 16 bits, no saturation
          ovf_reg[g] <= ovf_reg[g] + 16'h0001;
        end
      end

      // Alignment scratch register
      always_ff @(posedge clk) begin
        if (!rst_b) begin
          align_reg[g] <= RST_ALIGN;
        end else if (wr_dec[g][OFS_ALIGN]) begin
          align_reg[g] <= out_data[g];
        end
      end

      // Hardware revision
      always_ff @(posedge clk) begin
        if (!rst_b) begin
          hw_rev_reg[g] <= RST_HW_REV;
        end else if (wr_dec[g][OFS_HW_REV]) begin
          hw_rev_reg[g] <= out_data[g];
        end
      end

      // Gain trims; production values normally reloaded from storage
      always_ff @(posedge clk) begin
        if (!rst_b) begin
          vgain_reg[g] <= RST_TRIM;
          igain_reg[g] <= RST_TRIM;
        end else begin
          if (wr_dec[g][OFS_VGAIN]) begin
            vgain_reg[g] <= out_data[g];
          end
          if (wr_dec[g][OFS_IGAIN]) begin
            igain_reg[g] <= out_data[g];
          end
        end
      end

      // Code word; cleared by every restart so saving needs re-entry
      always_ff @(posedge clk) begin
        if (!rst_b) begin
          code_reg[g] <= RST_CODE_WORD;
        end else if (wr_dec[g][OFS_CODE_WORD]) begin
          code_reg[g] <= out_data[g];
        end
      end

      // Feature configuration, bit three selects the image mode
      always_ff @(posedge clk) begin
        if (!rst_b) begin
          feat_reg[g] <= RST_FEATURE;
        end else if (wr_dec[g][OFS_FEATURE]) begin
          feat_reg[g] <= out_data[g];
        end
      end

      // Energy scaling factor
      always_ff @(posedge clk) begin
        if (!rst_b) begin
          scale_reg[g] <= RST_SCALE;
        end else if (wr_dec[g][OFS_SCALE]) begin
          scale_reg[g] <= out_data[g];
        end
      end

      // Undervoltage threshold and transformer ratio divisor
      always_ff @(posedge clk) begin
        if (!rst_b) begin
          uv_reg[g]    <= RST_UV_THR;
          ratio_reg[g] <= RST_RATIO_DIV;
        end else begin
          if (wr_dec[g][OFS_UV_THR]) begin
            uv_reg[g] <= out_data[g];
          end
          if (wr_dec[g][OFS_RATIO_DIV]) begin
            ratio_reg[g] <= out_data[g];
          end
        end
      end

      // Min/max auto-clear count
      always_ff @(posedge clk) begin
        if (!rst_b) begin
          minmax_reg[g] <= RST_MINMAX;
        end else if (wr_dec[g][OFS_MINMAX]) begin
          minmax_reg[g] <= out_data[g];
        end
      end

      // Measuring cycle time
      always_ff @(posedge clk) begin
        if (!rst_b) begin
          cycle_reg[g] <= RST_CYCLE;
        end else if (wr_dec[g][OFS_CYCLE]) begin
          cycle_reg[g] <= out_data[g];
        end
      end

      // Read mux for this channel's copy of the set
      always_comb begin
        case (acc_addr[g])
          OFS_OVERFLOW:    rdata[g] = ovf_reg[g];
          OFS_DIAG:        rdata[g] = diag_state[g];
          OFS_TYPE_ID:     rdata[g] = TYPE_ID;
          OFS_FW_REV:      rdata[g] = FW_REV;
          OFS_MUX_SHIFT:   rdata[g] = VAL_MUX_SHIFT;
          OFS_SIG_CHAN:    rdata[g] = VAL_SIG_CHAN;
          OFS_MIN_LEN:     rdata[g] = VAL_MIN_LEN;
          OFS_DATA_STRUCT: rdata[g] = VAL_DATA_STRUCT;
          OFS_ALIGN:       rdata[g] = align_reg[g];
          OFS_HW_REV:      rdata[g] = hw_rev_reg[g];
          OFS_VGAIN:       rdata[g] = vgain_reg[g];
          OFS_IGAIN:       rdata[g] = igain_reg[g];
          OFS_SPECIAL_ID:  rdata[g] = SPECIAL_ID;
          OFS_CODE_WORD:   rdata[g] = code_reg[g];
          OFS_FEATURE:     rdata[g] = feat_reg[g];
          OFS_SCALE:       rdata[g] = scale_reg[g];
          OFS_UV_THR:      rdata[g] = uv_reg[g];
          OFS_RATIO_DIV:   rdata[g] = ratio_reg[g];
          OFS_MINMAX:      rdata[g] = minmax_reg[g];
          OFS_CYCLE:       rdata[g] = cycle_reg[g];
          // Write-only and reserved numbers read as zero
          default:         rdata[g] = '0;
        endcase
      end

      // Hook this channel's selector to its settings
      assign sel_if[g].ctrl_byte = cb[g];
      assign sel_if[g].flex_en   = feat_reg[g][FEAT_FLEX_BIT];
      assign sel_if[g].uv_limit  = uv_reg[g];
      assign sel_if[g].reg_rdata = rdata[g];

      pmpi_image_sel #(
        .CHAN       (g)
      ) u_sel (
        .clk        (clk),
        .rst_b      (rst_b),
        .meas_value (meas_value),
        .sel        (sel_if[g])
      );

      // Settings handed to the datapath
      assign feature_cfg[g]    = feat_reg[g];
      assign energy_scale[g]   = scale_reg[g];
      assign ratio_divisor[g]  = ratio_reg[g];
      assign minmax_count[g]   = minmax_reg[g];
      assign cycle_time[g]     = cycle_reg[g];
      assign gain_trim_volt[g] = vgain_reg[g];
      assign gain_trim_curr[g] = igain_reg[g];
    end
  endgenerate

  // Storage copy request: only when the code word unlocks saving.
  // Writes without it stay volatile and are lost on restart.
  always_ff @(posedge clk) begin
    if (!rst_b) begin
      nv_req_reg <= '0;
    end else begin
      for (int c = 0; c < NUM_CH; c++) begin
        nv_req_reg[c] <= (|(wr_dec[c] & NV_MASK)) &&
                         (code_reg[c] == USER_CODE_WORD);
      end
    end
  end

  // Register number of the latest new write, saved or not; lowest channel wins a tie
  always_ff @(posedge clk) begin
    if (!rst_b) begin
      nv_addr_reg <= '0;
    end else if (wr_new[0]) begin
      nv_addr_reg <= acc_addr[0];
    end else if (wr_new[1]) begin
      nv_addr_reg <= acc_addr[1];
    end else if (wr_new[2]) begin
      nv_addr_reg <= acc_addr[2];
    end
  end

  assign nv_save_req  = nv_req_reg;
  assign nv_save_addr = nv_addr_reg;

  // Input image straight from the selector flops
  assign input_word_one    = sel_if[0].data_word;
  assign input_word_two    = sel_if[1].data_word;
  assign input_word_three  = sel_if[2].data_word;
  assign status_byte_one   = sel_if[0].status_byte;
  assign status_byte_two   = sel_if[1].status_byte;
  assign status_byte_three = sel_if[2].status_byte;

endmodule : pmpi_regs

// [src/pmpi_pkg.sv]
/*
  Shared constants for the power meter process-image register bank:
  widths, register numbers, control and status byte fields, reset
  values and quantity selector codes.
  Assumes one controller-side clock domain; no bus, registers are
  reached through the control bytes and output data words only.
*/
package pmpi_pkg;

  // Widths and counts
  localparam int REG_W   = 16;
  localparam int ADDR_W  = 6;
  localparam int CB_W    = 8;
  localparam int NUM_CH  = 3;
  localparam int NUM_QTY = 16;
  localparam int NUM_REG = 64;

  typedef logic [REG_W-1:0]  pmpi_word_t;
  typedef logic [CB_W-1:0]   pmpi_byte_t;
  typedef logic [ADDR_W-1:0] pmpi_addr_t;
  typedef logic [1:0]        pmpi_phase_t;
  typedef logic [3:0]        pmpi_qty_t;

  // Control and status byte fields
  localparam int CB_REG_BIT = 7;
  localparam int CB_WR_BIT  = 6;
  localparam int CB_PH_HI   = 5;
  localparam int CB_PH_LO   = 4;
  localparam int CB_QTY_HI  = 3;
  localparam int CB_QTY_LO  = 0;
  localparam int CB_ADR_HI  = 5;
  localparam int FEAT_FLEX_BIT = 3;
  localparam pmpi_phase_t PHASE_RSVD = 2'h3;

  // Quantity selector codes
  localparam pmpi_qty_t QTY_CURRENT = 4'h0;
  localparam pmpi_qty_t QTY_VOLTAGE = 4'h1;
  localparam pmpi_qty_t QTY_POWER   = 4'h2;
  localparam pmpi_qty_t QTY_PFACTOR = 4'h3;

  // Register numbers
  localparam pmpi_addr_t OFS_OVERFLOW    = 6'h00;
  localparam pmpi_addr_t OFS_PWD_CHANGE  = 6'h05;
  localparam pmpi_addr_t OFS_DIAG        = 6'h06;
  localparam pmpi_addr_t OFS_COMMAND     = 6'h07;
  localparam pmpi_addr_t OFS_TYPE_ID     = 6'h08;
  localparam pmpi_addr_t OFS_FW_REV      = 6'h09;
  localparam pmpi_addr_t OFS_MUX_SHIFT   = 6'h0a;
  localparam pmpi_addr_t OFS_SIG_CHAN    = 6'h0b;
  localparam pmpi_addr_t OFS_MIN_LEN     = 6'h0c;
  localparam pmpi_addr_t OFS_DATA_STRUCT = 6'h0d;
  localparam pmpi_addr_t OFS_ALIGN       = 6'h0f;
  localparam pmpi_addr_t OFS_HW_REV      = 6'h10;
  localparam pmpi_addr_t OFS_VGAIN       = 6'h11;
  localparam pmpi_addr_t OFS_IGAIN       = 6'h12;
  localparam pmpi_addr_t OFS_SPECIAL_ID  = 6'h1d;
  localparam pmpi_addr_t OFS_CODE_WORD   = 6'h1f;
  localparam pmpi_addr_t OFS_FEATURE     = 6'h20;
  localparam pmpi_addr_t OFS_SCALE       = 6'h23;
  localparam pmpi_addr_t OFS_UV_THR      = 6'h24;
  localparam pmpi_addr_t OFS_RATIO_DIV   = 6'h25;
  localparam pmpi_addr_t OFS_MINMAX      = 6'h26;
  localparam pmpi_addr_t OFS_CYCLE       = 6'h27;

  // Reset and delivery values
  localparam pmpi_word_t RST_OVERFLOW    = 16'h0000;
  localparam pmpi_word_t RST_ALIGN       = 16'h0000;
  localparam pmpi_word_t RST_HW_REV      = 16'h0000;
  localparam pmpi_word_t RST_TRIM        = 16'h0400;
  localparam pmpi_word_t RST_CODE_WORD   = 16'h0000;
  localparam pmpi_word_t RST_FEATURE     = 16'h0020;
  localparam pmpi_word_t RST_SCALE       = 16'h0004;
  localparam pmpi_word_t RST_UV_THR      = 16'h0064;
  localparam pmpi_word_t RST_RATIO_DIV   = 16'h0001;
  localparam pmpi_word_t RST_MINMAX      = 16'h00c8;
  localparam pmpi_word_t RST_CYCLE       = 16'h0032;
  localparam pmpi_word_t VAL_MUX_SHIFT   = 16'h0230;
  localparam pmpi_word_t VAL_SIG_CHAN    = 16'h0318;
  localparam pmpi_word_t VAL_MIN_LEN     = 16'h1818;
  localparam pmpi_word_t VAL_DATA_STRUCT = 16'h0007;
  localparam pmpi_word_t USER_CODE_WORD  = 16'h1235;

  // Registers backed by nonvolatile storage
  localparam logic [NUM_REG-1:0] NV_MASK =
    (64'h1 << OFS_OVERFLOW) | (64'h1 << OFS_HW_REV) |
    (64'h1 << OFS_VGAIN) | (64'h1 << OFS_IGAIN) |
    (64'h1 << OFS_FEATURE) | (64'h1 << OFS_SCALE) |
    (64'h1 << OFS_UV_THR) | (64'h1 << OFS_RATIO_DIV) |
    (64'h1 << OFS_MINMAX) | (64'h1 << OFS_CYCLE);

endpackage : pmpi_pkg

// [src/pmpi_sel_if.sv]
/*
  Carrier between the register bank and one process-image selector:
  control byte, mode and limit settings in, answer word and status out.
  Assumes both ends share one clock.
*/
`timescale 1ns/1ns
interface pmpi_sel_if;
  import pmpi_pkg::*;
  pmpi_byte_t ctrl_byte;
  logic       flex_en;
  pmpi_word_t uv_limit;
  pmpi_word_t reg_rdata;
  pmpi_word_t data_word;
  pmpi_byte_t status_byte;

  modport bank  (output ctrl_byte, flex_en, uv_limit, reg_rdata,
                 input  data_word, status_byte);
  modport image (input  ctrl_byte, flex_en, uv_limit, reg_rdata,
                 output data_word, status_byte);
endinterface : pmpi_sel_if

// [src/pmpi_image_sel.sv]
/*
  Process-image selector for one input data word and its status byte.
  Assumes the control byte and measured values are synchronous to clk.
*/
`timescale 1ns/1ns
module pmpi_image_sel #(
  parameter int CHAN = 0
) (
  // Clock and reset
  input  wire logic clk,
  input  wire logic rst_b,
  // Measured values by phase and quantity
  input  wire logic [pmpi_pkg::NUM_CH-1:0][pmpi_pkg::NUM_QTY-1:0]
                    [pmpi_pkg::REG_W-1:0] meas_value,
  // Link to the register bank
  pmpi_sel_if.image sel
);
  import pmpi_pkg::*;

  localparam pmpi_phase_t OWN_PHASE = 2'(CHAN);

  logic        reg_mode;
  pmpi_phase_t phase_sel;
  pmpi_qty_t   qty_sel;
  pmpi_word_t  value;
  logic        uv_err;

  // Pick phase and quantity for this word
  always_comb begin
    reg_mode = sel.ctrl_byte[CB_REG_BIT];
    qty_sel  = sel.ctrl_byte[CB_QTY_HI:CB_QTY_LO];
    if (sel.flex_en) begin
      phase_sel = sel.ctrl_byte[CB_PH_HI:CB_PH_LO];
    end else begin
      phase_sel = OWN_PHASE;
    end
    // Codes 0..3 are current, voltage, power, power factor
    if (phase_sel == PHASE_RSVD) begin
      value = '0;
    end else begin
      value = meas_value[phase_sel][qty_sel];
    end
    uv_err = meas_value[OWN_PHASE][QTY_VOLTAGE] < sel.uv_limit;
  end

  // Answer word: register data or selected measurement
  always_ff @(posedge clk) begin
    if (!rst_b) begin
      sel.data_word <= '0;
    end else if (reg_mode) begin
      sel.data_word <= sel.reg_rdata;
    end else begin
      sel.data_word <= value;
    end
  end

  // Status: acknowledge in register mode, selectors otherwise
  always_ff @(posedge clk) begin
    if (!rst_b) begin
      sel.status_byte <= '0;
    end else if (reg_mode) begin
      sel.status_byte <= {1'b1, sel.ctrl_byte[CB_WR_BIT],
                          sel.ctrl_byte[CB_ADR_HI:0]};
    end else begin
      sel.status_byte <= {1'b0, uv_err, phase_sel, qty_sel};
    end
  end

endmodule : pmpi_image_sel

// [verification/pmpi_regs_properties.sv]
/*
  Channel-one checks for the process-image register bank.
  Assumes it is bound to pmpi_regs and sees only its ports.
*/
`timescale 1ns/1ns
module pmpi_regs_properties
  import pmpi_pkg::*;
(
  // Clock and reset
  input wire logic                   clk,
  input wire logic                   rst_b,
  // Channel one image and measured values
  input wire pmpi_pkg::pmpi_byte_t   control_byte_one,
  input wire pmpi_pkg::pmpi_word_t   output_word_one,
  input wire pmpi_pkg::pmpi_word_t   input_word_one,
  input wire pmpi_pkg::pmpi_byte_t   status_byte_one,
  input wire logic [2:0][15:0][15:0] meas_value,
  // Settings and save requests
  input wire logic [2:0][15:0]       feature_cfg,
  input wire logic [2:0][15:0]       energy_scale,
  input wire logic [2:0][15:0]       minmax_count,
  input wire logic [2:0]             nv_save_req
);
  logic        rst_q;
  pmpi_phase_t ph;
  logic [5:0]  sel;
  pmpi_word_t  exp_w;

  // Delayed reset keeps $past away from values taken during reset
  always_ff @(posedge clk) rst_q <= rst_b;

  // Expected answer of a process request; phase 3 reads as zero
  always_comb begin
    ph = feature_cfg[0][FEAT_FLEX_BIT] ? control_byte_one[5:4] : 2'h0;
    sel = {ph, control_byte_one[3:0]};
    exp_w = (ph == PHASE_RSVD) ? 16'h0000 : meas_value[ph][sel[3:0]];
  end

  default clocking cb_chk @(posedge clk); endclocking
  default disable iff (!rst_b);

  // A write that the bank must take: new data on a held write byte
  sequence s_new_wr(a);
    rst_q && control_byte_one == {2'b11, a} &&
      output_word_one != $past(output_word_one);
  endsequence

  property p_reg_ack;
    rst_q && control_byte_one[7] |=> status_byte_one[7] &&
      status_byte_one[5:0] == $past(control_byte_one[5:0]);
  endproperty
  a_reg_ack: assert property (p_reg_ack)
    else $error("register access not acknowledged");

  property p_proc_stat;
    rst_q && !control_byte_one[7] |=> !status_byte_one[7] &&
      status_byte_one[5:0] == $past(sel);
  endproperty
  a_proc_stat: assert property (p_proc_stat)
    else $error("process status selectors wrong");

  property p_proc_data;
    rst_q && !control_byte_one[7] |=> input_word_one == $past(exp_w);
  endproperty
  a_proc_data: assert property (p_proc_data)
    else $error("process word wrong");

  property p_reserved;
    rst_q && control_byte_one[7:6] == 2'b10 &&
      (control_byte_one[5:0] == 6'h0e || control_byte_one[5:0] > 6'h27)
      |=> input_word_one == 16'h0000;
  endproperty
  a_reserved: assert property (p_reserved)
    else $error("reserved register not zero");

  property p_scale_wr;
    s_new_wr(OFS_SCALE) |=> energy_scale[0] == $past(output_word_one);
  endproperty
  a_scale_wr: assert property (p_scale_wr)
    else $error("scale write lost");

  property p_minmax_wr;
    s_new_wr(OFS_MINMAX) |=> minmax_count[0] == $past(output_word_one);
  endproperty
  a_minmax_wr: assert property (p_minmax_wr)
    else $error("min max count write lost");

  property p_reset_vals;
    $rose(rst_b) |-> feature_cfg[0] == 16'h0020 &&
      energy_scale[0] == 16'h0004 && minmax_count[0] == 16'h00c8;
  endproperty
  a_reset_vals: assert property (p_reset_vals)
    else $error("settings not at delivery values");

  property p_nv_cause;
    nv_save_req[0] |-> $past(control_byte_one[7:6]) == 2'b11;
  endproperty
  a_nv_cause: assert property (p_nv_cause)
    else $error("save request without a write");
endmodule : pmpi_regs_properties

// [verification/pmpi_ctrl_model.sv]
/*
  Controller model: owns the three control bytes and output words.
  Assumes the bank samples them on the rising clock edge.
*/
`timescale 1ns/1ns
module pmpi_ctrl_model (
  // Clock
  input  wire logic            clk,
  // Output image toward the bank
  output pmpi_pkg::pmpi_byte_t cb [3],
  output pmpi_pkg::pmpi_word_t ow [3]
);
  import pmpi_pkg::*;

  // Quiet image until the bench asks for something
  initial begin
    cb = '{default: 8'h00};
    ow = '{default: 16'h0000};
  end

  // Change after a falling edge, hold across the answering rising edge
  task automatic put(input int ch, input pmpi_byte_t b,
                     input pmpi_word_t d);
    @(negedge clk);
    cb[ch] = b;
    ow[ch] = d;
    @(negedge clk);
  endtask : put

  task automatic proc(input int ch, input pmpi_phase_t p,
                      input pmpi_qty_t q);
    put(ch, {2'b00, p, q}, ow[ch]);
  endtask : proc

  task automatic rd(input int ch, input pmpi_addr_t a);
    put(ch, {2'b10, a}, ow[ch]);
  endtask : rd

  // Equal data on a held byte is not a new write, so vary the data
  task automatic wr(input int ch, input pmpi_addr_t a,
                    input pmpi_word_t d);
    put(ch, {2'b11, a}, d);
  endtask : wr
endmodule : pmpi_ctrl_model

// [verification/pmpi_regs_tb_top.sv]
/*
  Bench for the process-image bank: controller model, fixed measured
  values, hand-written scenarios. Assumes one 100 MHz clock.
*/
`timescale 1ns/1ns
module pmpi_regs_tb_top;
  import pmpi_pkg::*;
  // Clock, reset and tallies
  logic                   clk;
  logic                   rst_b;
  int                     num_errors;
  int                     compares;
  // Image both ways and datapath side
  pmpi_byte_t             cb [3];
  pmpi_word_t             ow [3];
  pmpi_word_t             iw [3];
  pmpi_byte_t             sb [3];
  logic [2:0][15:0][15:0] meas;
  logic [2:0][15:0]       scale;
  logic [2:0][15:0]       minmax;
  logic [2:0][15:0]       rdiv, cyct, gv, gc;
  logic [2:0]             nvr, wrap;
  pmpi_addr_t             nva;

  pmpi_ctrl_model u_ctrl (.clk(clk), .cb(cb), .ow(ow));
  pmpi_regs u_dut (
    .clk(clk), .rst_b(rst_b),
    .control_byte_one(cb[0]), .control_byte_two(cb[1]),
    .control_byte_three(cb[2]), .output_word_one(ow[0]),
    .output_word_two(ow[1]), .output_word_three(ow[2]),
    .meas_value(meas), .energy_wrap(wrap), .diag_state('0),
    .input_word_one(iw[0]), .input_word_two(iw[1]),
    .input_word_three(iw[2]), .status_byte_one(sb[0]),
    .status_byte_two(sb[1]), .status_byte_three(sb[2]),
    .feature_cfg(), .energy_scale(scale), .ratio_divisor(rdiv),
    .minmax_count(minmax), .cycle_time(cyct), .gain_trim_volt(gv),
    .gain_trim_curr(gc), .nv_save_req(nvr), .nv_save_addr(nva)
  );

  // Free-running clock
  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end

  // Compares, one per result kind
  task automatic chk_w(input pmpi_word_t got, input pmpi_word_t exp);
    compares++;
    if (got !== exp) begin
      num_errors++;
      $display("Error at %0t: word %h, expected %h", $time, got, exp);
    end
  endtask : chk_w

  task automatic chk_b(input pmpi_byte_t got, input pmpi_byte_t exp);
    compares++;
    if (got !== exp) begin
      num_errors++;
      $display("Error at %0t: status %h, expected %h", $time, got, exp);
    end
  endtask : chk_b

  task automatic rd_chk(input int ch, input pmpi_addr_t a,
                        input pmpi_word_t exp);
    u_ctrl.rd(ch, a);
    chk_w(iw[ch], exp);
    chk_b(sb[ch], {2'b10, a});
  endtask : rd_chk

  task automatic do_reset(input int n);
    @(negedge clk);
    rst_b = 1'b0;
    repeat (n) @(negedge clk);
    rst_b = 1'b1;
  endtask : do_reset

  task automatic t_defaults();
    pmpi_addr_t a [8] = '{OFS_OVERFLOW, OFS_MUX_SHIFT, OFS_DATA_STRUCT,
      OFS_FEATURE, OFS_SCALE, OFS_UV_THR, OFS_MINMAX, OFS_CYCLE};
    pmpi_word_t v [8] = '{16'h0000, 16'h0230, 16'h0007, 16'h0020,
      16'h0004, 16'h0064, 16'h00c8, 16'h0032};
    for (int ch = 0; ch < 3; ch++) begin
      for (int i = 0; i < 8; i++) begin
        rd_chk(ch, a[i], v[i]);
      end
    end
    $display("t_defaults done");
  endtask : t_defaults

  // Phase field set to another phase; simple mode must ignore it
  task automatic t_simple();
    for (int ch = 0; ch < 3; ch++) begin
      for (int q = 0; q < 4; q++) begin
        u_ctrl.proc(ch, 2'((ch + 1) % 3), 4'(q));
        chk_w(iw[ch], meas[ch][q]);
        chk_b(sb[ch], {2'b00, 2'(ch), 4'(q)});
      end
    end
    $display("t_simple done");
  endtask : t_simple

  task automatic t_flex();
    for (int ch = 0; ch < 3; ch++) begin
      u_ctrl.wr(ch, OFS_FEATURE, 16'h0028);
      for (int p = 0; p < 4; p++) begin
        for (int q = 0; q < 4; q++) begin
          u_ctrl.proc(ch, 2'(p), 4'(q));
          chk_w(iw[ch], p == 3 ? 16'h0000 : meas[p][q]);
          chk_b(sb[ch], {2'b00, 2'(p), 4'(q)});
        end
      end
      u_ctrl.wr(ch, OFS_FEATURE, 16'h0020);
      u_ctrl.proc(ch, 2'h1, 4'h2);
      chk_w(iw[ch], meas[ch][2]);
    end
    $display("t_flex done");
  endtask : t_flex

  task automatic t_regs();
    u_ctrl.wr(0, OFS_CODE_WORD, USER_CODE_WORD);
    u_ctrl.wr(0, OFS_SCALE, 16'h0009);
    chk_b({5'h0, nvr}, 8'h01);
    chk_b({2'b00, nva}, {2'b00, OFS_SCALE});
    u_ctrl.wr(0, OFS_MINMAX, 16'h0123);
    chk_w(scale[0], 16'h0009);
    chk_w(minmax[0], 16'h0123);
    rd_chk(1, OFS_SCALE, 16'h0004);
    rd_chk(0, OFS_SCALE, 16'h0009);
    u_ctrl.wr(0, OFS_OVERFLOW, 16'h0007);
    rd_chk(0, OFS_OVERFLOW, 16'h0007);
    u_ctrl.wr(0, 6'h0e, 16'h5a5a);
    rd_chk(0, 6'h0e, 16'h0000);
    u_ctrl.wr(0, 6'h28, 16'ha5a5);
    rd_chk(0, 6'h28, 16'h0000);
    @(negedge clk) wrap = 3'h1;
    @(negedge clk) wrap = 3'h0;
    rd_chk(0, OFS_OVERFLOW, 16'h0008);
    do_reset(2);
    chk_w(scale[0], 16'h0004);
    chk_w(minmax[0], 16'h00c8);
    chk_w(rdiv[0], 16'h0001);
    chk_w(cyct[0], 16'h0032);
    chk_w(gv[0], 16'h0400);
    chk_w(gc[0], 16'h0400);
    $display("t_regs done");
  endtask : t_regs

  task automatic results();
    $display("Compares %0d, mismatches %0d", compares, num_errors);
    if (num_errors == 0 && compares > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask : results

  // Watchdog: the scenarios need well under a thousand cycles
  initial begin
    repeat (5000) @(posedge clk);
    num_errors++;
    $display("Error at %0t: watchdog expired", $time);
    results();
  end

  // Main sequence
  initial begin
    rst_b = 1'b0;
    num_errors = 0;
    compares = 0;
    wrap = 3'h0;
    for (int p = 0; p < 3; p++) begin
      for (int q = 0; q < 16; q++) begin
        meas[p][q] = {4'h4, 4'(p), 4'(q), 4'h9};
      end
    end
    do_reset(20);
    t_defaults();
    t_simple();
    t_flex();
    t_regs();
    results();
  end
endmodule : pmpi_regs_tb_top

bind pmpi_regs pmpi_regs_properties u_props (
  .clk(clk), .rst_b(rst_b), .control_byte_one(control_byte_one),
  .output_word_one(output_word_one), .input_word_one(input_word_one),
  .status_byte_one(status_byte_one), .meas_value(meas_value),
  .feature_cfg(feature_cfg), .energy_scale(energy_scale),
  .minmax_count(minmax_count), .nv_save_req(nv_save_req)
);
